// *** imtp_consts.svh ***
`ifndef IMTP_CONSTS_SVH
`define IMTP_CONSTS_SVH

// Register byte addresses
`define IMTP_ADDR_CFG        32'h4004_4000
`define IMTP_ADDR_CTRL       32'h4004_4004
`define IMTP_ADDR_IER        32'h4004_4010
`define IMTP_ADDR_IDR        32'h4004_4014
`define IMTP_ADDR_IMR        32'h4004_4018
`define IMTP_ADDR_ISR        32'h4004_401C
`define IMTP_ADDR_TRACE      32'h4004_4020
`define IMTP_ADDR_DSCR       32'h4004_4030
`define IMTP_ADDR_HASH       32'h4004_4034
`define IMTP_ADDR_UIH        32'h4004_4038

// Field positions
`define IMTP_CTRL_RESET_BIT  2
`define IMTP_CFG_USER_BIT    13
`define IMTP_INT_FLAG_BIT    24
`define IMTP_DSCR_LSB        6
`define IMTP_HASH_LSB        7
`define IMTP_TRACE_W         3

// Sizes and reset values
`define IMTP_UIH_WORDS       8
`define IMTP_UIH_IDX_W       3
`define IMTP_WORD_STRIDE     4
`define IMTP_RESET_WORD      32'h0000_0000

// Trace cause encodings
`define IMTP_CAUSE_MEMBER    3'h0
`define IMTP_CAUSE_CFG       3'h1
`define IMTP_CAUSE_DSCR      3'h2
`define IMTP_CAUSE_HASH      3'h3
`define IMTP_CAUSE_READ      3'h4
`define IMTP_NUM_CAUSES      5

`endif

// *** imtp_hash_words.sv ***
`timescale 1ns/10ps
`include "imtp_consts.svh"

module imtp_hash_words #(
    parameter int WORDS = `IMTP_UIH_WORDS,
    parameter int IDX_W = `IMTP_UIH_IDX_W
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                ce,
    // Write port
    input  wire logic                wr,
    input  wire logic [IDX_W-1:0]    idx,
    input  wire logic [31:0]         wdata,
    input  wire logic                sw_clear,
    // Stored words, word 0 in the low bits
    output logic [WORDS*32-1:0]      words_q
);

    // Bytes are kept exactly as written; software supplies them reversed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            words_q <= '0;
        end else if (ce) begin
            if (sw_clear) begin
                words_q <= '0;
            end else if (wr) begin
                words_q[idx*32 +: 32] <= wdata;
            end
        end
    end

endmodule

// *** imtp_pkg.sv ***
`include "imtp_consts.svh"

package imtp_pkg;

    typedef enum logic [`IMTP_TRACE_W-1:0] {
        IMTP_CAUSE_BAD_DESCRIPTOR_MEMBER     = `IMTP_CAUSE_MEMBER,
        IMTP_CAUSE_CONFIG_CHANGED            = `IMTP_CAUSE_CFG,
        IMTP_CAUSE_DESCRIPTOR_POINTER_CHANGED = `IMTP_CAUSE_DSCR,
        IMTP_CAUSE_HASH_POINTER_CHANGED      = `IMTP_CAUSE_HASH,
        IMTP_CAUSE_WRITE_ONLY_READ           = `IMTP_CAUSE_READ
    } imtp_cause_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } imtp_bus_req_t;

endpackage

// *** imtp_sva.sv ***
`timescale 1ns/10ps
`include "imtp_consts.svh"
module imtp_sva (
    // Clock and reset
    input wire logic                            clk,
    input wire logic                            reset_n,
    input wire logic                            ce,
    // Register port
    input wire imtp_pkg::imtp_bus_req_t         bus_req,
    input wire logic [31:0]                     rdata_q,
    // Monitor status
    input wire logic                            monitoring_active,
    input wire logic                            bad_member_detect,
    // Design outputs
    input wire logic [31:0]                     descriptor_area_pointer_q,
    input wire logic [31:0]                     hash_area_pointer_q,
    input wire logic                            user_initial_hash_select_q,
    input wire logic [`IMTP_UIH_WORDS*32-1:0]   user_initial_hash_words_q,
    input wire logic                            monitor_reset_q,
    input wire logic                            irq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire wr_ok = ce && bus_req.wr;
    wire rd_ok = ce && bus_req.rd;
    property p_dscr_low; descriptor_area_pointer_q[5:0] == 6'h00; endproperty
    a_dscr_low: assert property (p_dscr_low) else $error("descriptor pointer low bits set");
    property p_hash_low; hash_area_pointer_q[6:0] == 7'h00; endproperty
    a_hash_low: assert property (p_hash_low) else $error("hash pointer low bits set");
    property p_dscr_wr; wr_ok && bus_req.addr == `IMTP_ADDR_DSCR
        |=> descriptor_area_pointer_q == ($past(bus_req.wdata) & 32'hFFFF_FFC0); endproperty
    a_dscr_wr: assert property (p_dscr_wr) else $error("descriptor pointer not stored");
    property p_hash_wr; wr_ok && bus_req.addr == `IMTP_ADDR_HASH
        |=> hash_area_pointer_q == ($past(bus_req.wdata) & 32'hFFFF_FF80); endproperty
    a_hash_wr: assert property (p_hash_wr) else $error("hash pointer not stored");
    property p_cfg_wr; wr_ok && bus_req.addr == `IMTP_ADDR_CFG
        |=> user_initial_hash_select_q == $past(bus_req.wdata[`IMTP_CFG_USER_BIT]); endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("hash select not stored");
    property p_uih_wr; wr_ok && bus_req.addr == `IMTP_ADDR_UIH
        |=> user_initial_hash_words_q[31:0] == $past(bus_req.wdata); endproperty
    a_uih_wr: assert property (p_uih_wr) else $error("user word 0 not stored");
    property p_wo_read; rd_ok && bus_req.addr inside {`IMTP_ADDR_CTRL, `IMTP_ADDR_IER, `IMTP_ADDR_IDR}
        |=> rdata_q == 32'h0000_0000; endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only register returned data");
    property p_trace_rd; rd_ok && bus_req.addr == `IMTP_ADDR_TRACE |=> rdata_q[31:3] == 29'h0; endproperty
    a_trace_rd: assert property (p_trace_rd) else $error("trace upper bits not zero");
    property p_soft_reset; wr_ok && bus_req.addr == `IMTP_ADDR_CTRL && bus_req.wdata[`IMTP_CTRL_RESET_BIT]
        |=> monitor_reset_q && descriptor_area_pointer_q == 32'h0000_0000 ##1 !irq_q; endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("software reset did not clear");
    property p_mask_off; wr_ok && bus_req.addr == `IMTP_ADDR_IDR && bus_req.wdata[`IMTP_INT_FLAG_BIT]
        |-> ##2 !irq_q; endproperty
    a_mask_off: assert property (p_mask_off) else $error("interrupt stayed up after disable");
endmodule

bind imtp_top imtp_sva u_sva (.clk, .reset_n, .ce, .bus_req, .rdata_q, .monitoring_active,
    .bad_member_detect, .descriptor_area_pointer_q, .hash_area_pointer_q, .user_initial_hash_select_q,
    .user_initial_hash_words_q, .monitor_reset_q, .irq_q);

// *** imtp_top.sv ***
`timescale 1ns/10ps
`include "imtp_consts.svh"

// Summary of operation
// - The trace field holds a 3-bit cause: 0 bad descriptor member, 1 config write, 2 descriptor pointer write, 3 hash pointer write, 4 write-only read.
// - A descriptor loaded with an unspecified member set to one is reported as an undefined access.
// - Writing the configuration register while region monitoring is active is reported with cause 1.
// - Writing the descriptor area pointer while region monitoring is active is reported with cause 2.
// - Writing the hash area pointer while region monitoring is active is reported with cause 3.
// - Any software read of a write-only register is reported with cause 4.
// - Only the first undefined access is traced; later ones leave the stored cause alone.
// - Only the software reset bit of the control register clears the trace; reading it does not.
// - The descriptor area pointer keeps bits 31 to 6 and software must give a 64-byte aligned address.
// - The hash area pointer keeps bits 31 to 7 and software must give a 128-byte aligned address.
// - With the user hash select bit set, the hashing engine uses the eight write-only user words instead of constants.
// - The undefined access flag is set after any undefined access and cleared only by software reset.
// - The undefined access interrupt is raised only while its mask is set; enable sets and disable clears the mask.
module imtp_top (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  ce,
    // Register port
    input  wire imtp_pkg::imtp_bus_req_t bus_req,
    output logic [31:0]                rdata_q,
    // Monitor status inputs
    input  wire logic                  monitoring_active,
    input  wire logic                  bad_member_detect,
    // Towards the hashing engine
    output logic [31:0]                descriptor_area_pointer_q,
    output logic [31:0]                hash_area_pointer_q,
    output logic                       user_initial_hash_select_q,
    output logic [`IMTP_UIH_WORDS*32-1:0] user_initial_hash_words_q,
    output logic                       monitor_reset_q,
    // Interrupt
    output logic                       irq_q
);

    localparam logic [31:0] UIH_LAST =
        `IMTP_ADDR_UIH + 32'((`IMTP_UIH_WORDS - 1) * `IMTP_WORD_STRIDE);

    // Address decode shared by the read and write paths
    function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
        return a == reg_addr;
    endfunction

    function automatic logic hit_uih(input logic [31:0] a);
        return (a >= `IMTP_ADDR_UIH) && (a <= UIH_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [`IMTP_UIH_IDX_W-1:0] uih_index(input logic [31:0] a);
        logic [31:0] d;
        d = a - `IMTP_ADDR_UIH;
        return d[`IMTP_UIH_IDX_W+1:2];
    endfunction

    // Write-only registers: reading them counts as an undefined access
    function automatic logic is_write_only(input logic [31:0] a);
        return hit(a, `IMTP_ADDR_CTRL) || hit(a, `IMTP_ADDR_IER) ||
               hit(a, `IMTP_ADDR_IDR) || hit_uih(a);
    endfunction

    // Decoded strobes
    logic wr_cfg;
    logic wr_ctrl;
    logic wr_ier;
    logic wr_idr;
    logic wr_dscr;
    logic wr_hash;
    logic wr_uih;
    logic rd_wo;
    logic sw_reset;

    // Full 32-bit compare, so no register shows up at an alias
    always_comb begin
        wr_cfg  = 1'b0;
        wr_ctrl = 1'b0;
        wr_ier  = 1'b0;
        wr_idr  = 1'b0;
        wr_dscr = 1'b0;
        wr_hash = 1'b0;
        wr_uih  = 1'b0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                `IMTP_ADDR_CFG: begin
                    wr_cfg = 1'b1;
                end
                `IMTP_ADDR_CTRL: begin
                    wr_ctrl = 1'b1;
                end
                `IMTP_ADDR_IER: begin
                    wr_ier = 1'b1;
                end
                `IMTP_ADDR_IDR: begin
                    wr_idr = 1'b1;
                end
                `IMTP_ADDR_DSCR: begin
                    wr_dscr = 1'b1;
                end
                `IMTP_ADDR_HASH: begin
                    wr_hash = 1'b1;
                end
                // User hash word addresses raise wr_uih; read-only and unmapped addresses raise no strobe
                default: begin
                    wr_uih = hit_uih(bus_req.addr);
                end
            endcase
        end
    end

    // Reads of write-only locations are traced but return zero
    assign rd_wo    = bus_req.rd && is_write_only(bus_req.addr);
    assign sw_reset = wr_ctrl && bus_req.wdata[`IMTP_CTRL_RESET_BIT];

    // Undefined access events, indexed by cause code
    logic [`IMTP_NUM_CAUSES-1:0] ua_event;

    always_comb begin
        ua_event = '0;
        ua_event[`IMTP_CAUSE_MEMBER] = bad_member_detect;
        ua_event[`IMTP_CAUSE_CFG]    = wr_cfg && monitoring_active;
        ua_event[`IMTP_CAUSE_DSCR]   = wr_dscr && monitoring_active;
        ua_event[`IMTP_CAUSE_HASH]   = wr_hash && monitoring_active;
        ua_event[`IMTP_CAUSE_READ]   = rd_wo;
    end

    // Trace capture and sticky flag
    imtp_pkg::imtp_cause_t trace_cause;
    logic                  ua_flag;

    imtp_trace u_trace (
        .clk      (clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .event_in (ua_event),
        .sw_clear (sw_reset),
        .cause_q  (trace_cause),
        .flag_q   (ua_flag)
    );

    // User starting hash words
    imtp_hash_words #(
        .WORDS (`IMTP_UIH_WORDS),
        .IDX_W (`IMTP_UIH_IDX_W)
    ) u_words (
        .clk      (clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .wr       (wr_uih),
        .idx      (uih_index(bus_req.addr)),
        .wdata    (bus_req.wdata),
        .sw_clear (sw_reset),
        .words_q  (user_initial_hash_words_q)
    );

    // Configuration: only the user hash select bit lives here.
    // The write still takes effect during monitoring; it is merely traced.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            user_initial_hash_select_q <= 1'b0;
        end else if (ce) begin
            if (sw_reset) begin
                user_initial_hash_select_q <= 1'b0;
            end else if (wr_cfg) begin
                user_initial_hash_select_q <= bus_req.wdata[`IMTP_CFG_USER_BIT];
            end
        end
    end

    // Descriptor area pointer, low bits held at zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            descriptor_area_pointer_q <= `IMTP_RESET_WORD;
        end else if (ce) begin
            if (sw_reset) begin
                descriptor_area_pointer_q <= `IMTP_RESET_WORD;
            end else if (wr_dscr) begin
                descriptor_area_pointer_q <= {bus_req.wdata[31:`IMTP_DSCR_LSB],
                                              `IMTP_DSCR_LSB'(0)};
            end
        end
    end

    // Hash area pointer, low bits held at zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hash_area_pointer_q <= `IMTP_RESET_WORD;
        end else if (ce) begin
            if (sw_reset) begin
                hash_area_pointer_q <= `IMTP_RESET_WORD;
            end else if (wr_hash) begin
                hash_area_pointer_q <= {bus_req.wdata[31:`IMTP_HASH_LSB],
                                        `IMTP_HASH_LSB'(0)};
            end
        end
    end

    // Interrupt mask: enable sets, disable clears; disable wins if both
    logic ua_mask_q;
    logic ua_mask_d;
    logic mask_set;
    logic mask_clr;

    assign mask_set = wr_ier && bus_req.wdata[`IMTP_INT_FLAG_BIT];
    assign mask_clr = wr_idr && bus_req.wdata[`IMTP_INT_FLAG_BIT];

    always_comb begin
        ua_mask_d = ua_mask_q;
        if (mask_clr) begin
            ua_mask_d = 1'b0;
        end else if (mask_set) begin
            ua_mask_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ua_mask_q <= 1'b0;
        end else if (ce) begin
            if (sw_reset) begin
                ua_mask_q <= 1'b0;
            end else begin
                ua_mask_q <= ua_mask_d;
            end
        end
    end

    // Level interrupt, one cycle behind the flag and the mask
    logic irq_d;

    assign irq_d = ua_flag && ua_mask_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= irq_d;
        end
    end

    // Reset pulse for the rest of the monitor
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            monitor_reset_q <= 1'b0;
        end else if (ce) begin
            monitor_reset_q <= sw_reset;
        end
    end

    // Read data mux; reads of write-only registers are traced with cause 4, other reads have no side effect on the trace
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = `IMTP_RESET_WORD;
        case (bus_req.addr)
            `IMTP_ADDR_CFG: begin
                rd_mux[`IMTP_CFG_USER_BIT] = user_initial_hash_select_q;
            end
            `IMTP_ADDR_CTRL, `IMTP_ADDR_IER, `IMTP_ADDR_IDR: begin
                rd_mux = `IMTP_RESET_WORD;
            end
            `IMTP_ADDR_IMR: begin
                rd_mux[`IMTP_INT_FLAG_BIT] = ua_mask_q;
            end
            `IMTP_ADDR_ISR: begin
                rd_mux[`IMTP_INT_FLAG_BIT] = ua_flag;
            end
            `IMTP_ADDR_TRACE: begin
                rd_mux[`IMTP_TRACE_W-1:0] = trace_cause;
            end
            `IMTP_ADDR_DSCR: begin
                rd_mux = descriptor_area_pointer_q;
            end
            `IMTP_ADDR_HASH: begin
                rd_mux = hash_area_pointer_q;
            end
            default: begin
                rd_mux = `IMTP_RESET_WORD;
            end
        endcase
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= `IMTP_RESET_WORD;
        end else if (ce) begin
            if (bus_req.rd) begin
                rdata_q <= rd_mux;
            end else begin
                rdata_q <= `IMTP_RESET_WORD;
            end
        end
    end

endmodule

// *** imtp_trace.sv ***
`timescale 1ns/10ps
`include "imtp_consts.svh"

module imtp_trace (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   ce,
    // Events, one bit per cause code
    input  wire logic [`IMTP_NUM_CAUSES-1:0] event_in,
    input  wire logic                   sw_clear,
    // Captured state
    output imtp_pkg::imtp_cause_t       cause_q,
    output logic                        flag_q
);

    // Lowest cause code wins when several events coincide
    function automatic imtp_pkg::imtp_cause_t first_cause(input logic [`IMTP_NUM_CAUSES-1:0] ev);
        imtp_pkg::imtp_cause_t c;
        c = imtp_pkg::IMTP_CAUSE_BAD_DESCRIPTOR_MEMBER;
        for (int i = `IMTP_NUM_CAUSES - 1; i >= 0; i--) begin
            if (ev[i]) begin
                c = imtp_pkg::imtp_cause_t'(i[`IMTP_TRACE_W-1:0]);
            end
        end
        return c;
    endfunction

    logic any_event;
    assign any_event = |event_in;

    // An event in the clearing cycle is still recorded
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cause_q <= imtp_pkg::IMTP_CAUSE_BAD_DESCRIPTOR_MEMBER;
            flag_q  <= 1'b0;
        end else if (ce) begin
            if (any_event && (!flag_q || sw_clear)) begin
                cause_q <= first_cause(event_in);
                flag_q  <= 1'b1;
            end else if (sw_clear) begin
                cause_q <= imtp_pkg::IMTP_CAUSE_BAD_DESCRIPTOR_MEMBER;
                flag_q  <= 1'b0;
            end
        end
    end

endmodule

// *** integrity_monitor_trace_and_pointers_tb.sv ***
`timescale 1ns/10ps
`include "imtp_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
module integrity_monitor_trace_and_pointers_tb;
    logic                            clk = 1'b0;
    logic                            reset_n = 1'b0;
    logic                            ce = 1'b1;
    logic                            monitoring_active = 1'b0;
    logic                            bad_member_detect = 1'b0;
    imtp_pkg::imtp_bus_req_t         bus_req = '0;
    logic [31:0]                     rdata_q;
    logic [31:0]                     descriptor_area_pointer_q;
    logic [31:0]                     hash_area_pointer_q;
    logic                            user_initial_hash_select_q;
    logic [`IMTP_UIH_WORDS*32-1:0]   user_initial_hash_words_q;
    logic                            monitor_reset_q;
    logic                            irq_q;
    int                              mismatches = 0;
    int                              tests_run = 0;
    int                              cycles = 0;
    int                              seed = 29598;
    logic [31:0]                     v;
    logic [31:0]                     d;
    logic [31:0]                     sha[8] = '{32'h6A09_E667, 32'hBB67_AE85, 32'h3C6E_F372, 32'hA54F_F53A,
                                                32'h510E_527F, 32'h9B05_688C, 32'h1F83_D9AB, 32'h5BE0_CD19};
    logic [31:0]                     zr[5] = '{`IMTP_ADDR_TRACE, `IMTP_ADDR_ISR, `IMTP_ADDR_IMR,
                                               `IMTP_ADDR_DSCR, `IMTP_ADDR_HASH};

    imtp_top u_dut (.clk, .reset_n, .ce, .bus_req, .rdata_q, .monitoring_active, .bad_member_detect,
        .descriptor_area_pointer_q, .hash_area_pointer_q, .user_initial_hash_select_q,
        .user_initial_hash_words_q, .monitor_reset_q, .irq_q);

    always #10 clk = ~clk;

    function automatic logic [31:0] exp_ptr(logic [31:0] x, int lsb);
        return x & ~((32'h0000_0001 << lsb) - 32'h0000_0001);
    endfunction
    function automatic logic [31:0] exp_trace(int c);
        return {29'h0, c[2:0]};
    endfunction
    // Software hands the hash words over byte-reversed
    function automatic logic [31:0] rev(logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    task automatic close_out();
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic wr(input logic [31:0] a, input logic [31:0] x);
        @(posedge clk) bus_req <= '{a, x, 1'b1, 1'b0};
        @(posedge clk) bus_req.wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] x);
        @(posedge clk) bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk) bus_req.rd <= 1'b0;
        #1 x = rdata_q;
    endtask
    task automatic provoke(input int c);
        logic [31:0] pa;
        pa = (c == 1) ? `IMTP_ADDR_CFG : (c == 2) ? `IMTP_ADDR_DSCR : `IMTP_ADDR_HASH;
        if (c == 0) begin
            @(posedge clk) bad_member_detect <= 1'b1;
            @(posedge clk) bad_member_detect <= 1'b0;
        end else if (c == 4) begin
            rd(`IMTP_ADDR_CTRL, d);
            `CHK(d, 32'h0000_0000)
        end else begin
            @(posedge clk) monitoring_active <= 1'b1;
            wr(pa, $random(seed));
            @(posedge clk) monitoring_active <= 1'b0;
        end
    endtask

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        foreach (zr[i]) begin
            rd(zr[i], d);
            `CHK(d, 32'h0000_0000)
        end
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            wr(`IMTP_ADDR_DSCR, v);
            `CHK(descriptor_area_pointer_q, exp_ptr(v, `IMTP_DSCR_LSB))
            rd(`IMTP_ADDR_DSCR, d);
            `CHK(d, exp_ptr(v, `IMTP_DSCR_LSB))
            wr(`IMTP_ADDR_HASH, v);
            rd(`IMTP_ADDR_HASH, d);
            `CHK(d, exp_ptr(v, `IMTP_HASH_LSB))
        end
        wr(`IMTP_ADDR_TRACE, 32'hFFFF_FFFF);
        wr(32'h4004_4060, 32'hFFFF_FFFF);
        rd(32'h4004_4060, d);
        `CHK(d, 32'h0000_0000)
        rd(`IMTP_ADDR_TRACE, d);
        `CHK(d, 32'h0000_0000)
        rd(`IMTP_ADDR_ISR, d);
        `CHK(d, 32'h0000_0000)
        for (int c = 0; c < `IMTP_NUM_CAUSES; c++) begin
            wr(`IMTP_ADDR_CTRL, 32'h0000_0004);
            if (c[0])
                wr(`IMTP_ADDR_IER, 32'h0100_0000);
            provoke(c);
            provoke((c + 1) % `IMTP_NUM_CAUSES);
            rd(`IMTP_ADDR_TRACE, d);
            `CHK(d, exp_trace(c))
            rd(`IMTP_ADDR_TRACE, d);
            `CHK(d, exp_trace(c))
            rd(`IMTP_ADDR_ISR, d);
            `CHK(d, 32'h0100_0000)
            `CHK(irq_q, c[0])
            wr(`IMTP_ADDR_IDR, 32'h0100_0000);
            @(posedge clk) #1;
            `CHK(irq_q, 1'b0)
            rd(`IMTP_ADDR_ISR, d);
            `CHK(d, 32'h0100_0000)
        end
        wr(`IMTP_ADDR_CTRL, 32'h0000_0004);
        rd(`IMTP_ADDR_TRACE, d);
        `CHK(d, 32'h0000_0000)
        rd(`IMTP_ADDR_ISR, d);
        `CHK(d, 32'h0000_0000)
        // A write while the clock enable is low must leave the pointer alone
        @(posedge clk) ce <= 1'b0;
        wr(`IMTP_ADDR_DSCR, 32'h0000_1000);
        `CHK(descriptor_area_pointer_q, 32'h0000_0000)
        @(posedge clk) ce <= 1'b1;
        wr(`IMTP_ADDR_CFG, 32'h0000_2000);
        `CHK(user_initial_hash_select_q, 1'b1)
        for (int i = 0; i < `IMTP_UIH_WORDS; i++)
            wr(`IMTP_ADDR_UIH + `IMTP_WORD_STRIDE * i, rev(sha[i]));
        for (int i = 0; i < `IMTP_UIH_WORDS; i++)
            `CHK(user_initial_hash_words_q[i*32+:32], rev(sha[i]))
        rd(`IMTP_ADDR_UIH + 32'h0000_001C, d);
        `CHK(d, 32'h0000_0000)
        rd(`IMTP_ADDR_TRACE, d);
        `CHK(d, exp_trace(4))
        close_out();
    end
endmodule
